/* src/rsm_pkg.sv */
// package for the reset source manager: register map, cause bit positions, filter timing
// assumes a single 20 MHz clock and an AXI4-Lite register port
package rsm_pkg;
  localparam logic [11:0] OFF_CONTROL = 12'h000;
  localparam logic [11:0] OFF_CAUSE = 12'h004;
  localparam logic [11:0] OFF_COMMAND = 12'h008;
  localparam int CTRL_HANG_DIS_BIT = 0;
  localparam int CMD_CLEAR_BIT = 0;
  localparam int AUX_CLEAR_BIT = 0;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [10:0] CAUSE_RESET = 11'h000;
  localparam int C_POWER_ON = 0;
  localparam int C_UNREG = 1;
  localparam int C_REG = 2;
  localparam int C_PIN = 3;
  localparam int C_WDOG = 4;
  localparam int C_HANG = 5;
  localparam int C_SWREQ = 6;
  localparam int C_SLEEP = 7;
  localparam int C_WAKE = 8;
  localparam int C_ANA0 = 9;
  localparam int C_ANA1 = 10;
  localparam int CAUSE_W = 11;
  localparam int CLK_MHZ = 20;
  localparam int PIN_FILTER_NS = 200;
  localparam int PIN_FILTER_CYC = (PIN_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic unreg_n;
    logic reg_n;
    logic ana0_n;
    logic ana1_n;
  } rsm_supply_t;

  typedef struct packed {
    logic system_reset_n;
    logic debug_reset_n;
  } rsm_reset_out_t;
endpackage

/* src/rsm_reset_source_manager.sv */
// reset source manager: merges reset sources into system and debug resets, keeps cause bits
// assumes the cause flops sit in an always-on domain reset only by aresetn (power-on)
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps

// Function
// RULE_01: four independent supply monitor reset inputs
// RULE_02: low supply line holds reset while low
// RULE_03: low external pin resets; idle high
// RULE_04: glitch filter on external reset pin
// RULE_05: watchdog expiry applies reset
// RULE_06: core hang resets system, not debug
// RULE_07: control bit 0 disables core hang reset
// RULE_08: software request resets system except debug
// RULE_09: deep sleep entry sets cause bit 7
// RULE_10: pin wake from deep sleep sets bit 8
// RULE_11: power-on sets cause bit 0
// RULE_12: unregulated supply low sets bit 1
// RULE_13: regulated supply low sets bit 2
// RULE_14: external pin reset sets bit 3
// RULE_15: watchdog reset sets bit 4
// RULE_16: hang sets bit 5, request bit 6
// RULE_17: analog domain monitors set bits 9, 10
// RULE_18: command bit 0 clears bits 5, 6
// RULE_19: control 0x000, cause 0x004, command 0x008
// RULE_20: power, supply, watchdog, pin reset debug too
// RULE_21: software clears: command, aux high, aux low
// RULE_22: causes accumulate across later resets
// RULE_23: cause flops outside the reset they record
// RULE_24: command reads zero; writing 0 does nothing
module rsm_reset_source_manager #(
  parameter int FILTER_CYC = rsm_pkg::PIN_FILTER_CYC
) (
  // clock and power-on reset
  input wire logic aclk,
  input wire logic aresetn,
  // reset sources
  input wire rsm_pkg::rsm_supply_t supply_low_n,
  input wire logic ext_reset_pin_n,
  input wire logic watchdog_expired,
  input wire logic core_hang,
  input wire logic sw_system_reset_request,
  input wire logic deepest_sleep_mode,
  input wire logic deep_sleep_pin_wake,
  input wire logic aux_cause_clear,
  // reset outputs
  output rsm_pkg::rsm_reset_out_t reset_out,
  // axi4-lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // a one-cycle filter would pass any single-cycle glitch, so two is the floor
  if (FILTER_CYC < 2 || FILTER_CYC > 255)
  begin : g_bad_filter
    $error("FILTER_CYC out of range");
  end

  logic hang_dis_r;
  logic [rsm_pkg::CAUSE_W-1:0] cause_r;
  logic [7:0] filt_cnt_r;
  logic pin_rst_r;
  logic aux_d_r;
  logic clear_armed_r;
  logic por_seen_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_have_r;
  logic w_have_r;
  logic cmd_clear;
  logic full_rst;
  logic sys_only_rst;
  logic hang_rst;
  logic wr_go;
  logic [rsm_pkg::CAUSE_W-1:0] cause_set;
  logic [rsm_pkg::CAUSE_W-1:0] cause_clr;

  // pin must stay low for FILTER_CYC cycles before it counts; pull-up keeps it idle high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      filt_cnt_r <= 8'h00;
      pin_rst_r <= 1'b0;
    end
    else if (ext_reset_pin_n) // see RULE_03
    begin
      filt_cnt_r <= 8'h00;
      pin_rst_r <= 1'b0;
    end
    else if (filt_cnt_r == 8'(FILTER_CYC - 1)) // see RULE_04
      pin_rst_r <= 1'b1;
    else
      filt_cnt_r <= filt_cnt_r + 8'h01;
  end

  assign hang_rst = core_hang && !hang_dis_r; // see RULE_07
  // levels held as long as the source stays active
  assign full_rst = !supply_low_n.unreg_n || !supply_low_n.reg_n // see RULE_02
    || !supply_low_n.ana0_n || !supply_low_n.ana1_n || pin_rst_r // see RULE_01
    || watchdog_expired; // see RULE_05
  assign sys_only_rst = hang_rst || sw_system_reset_request; // see RULE_08

  // debug reset only from the whole-system sources
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reset_out.system_reset_n <= 1'b0;
      reset_out.debug_reset_n <= 1'b0;
    end
    else
    begin
      reset_out.system_reset_n <= !(full_rst || sys_only_rst); // see RULE_06
      reset_out.debug_reset_n <= !full_rst; // see RULE_20
    end
  end

  always_comb
  begin
    cause_set = '0;
    cause_set[rsm_pkg::C_POWER_ON] = !por_seen_r; // see RULE_11
    cause_set[rsm_pkg::C_UNREG] = !supply_low_n.unreg_n; // see RULE_12
    cause_set[rsm_pkg::C_REG] = !supply_low_n.reg_n; // see RULE_13
    cause_set[rsm_pkg::C_PIN] = pin_rst_r; // see RULE_14
    cause_set[rsm_pkg::C_WDOG] = watchdog_expired; // see RULE_15
    cause_set[rsm_pkg::C_HANG] = hang_rst; // see RULE_16
    cause_set[rsm_pkg::C_SWREQ] = sw_system_reset_request; // see RULE_16
    cause_set[rsm_pkg::C_SLEEP] = deepest_sleep_mode; // see RULE_09
    cause_set[rsm_pkg::C_WAKE] = deep_sleep_pin_wake; // see RULE_10
    cause_set[rsm_pkg::C_ANA0] = !supply_low_n.ana0_n; // see RULE_17
    cause_set[rsm_pkg::C_ANA1] = !supply_low_n.ana1_n; // see RULE_17
    cause_clr = '0;
    cause_clr[rsm_pkg::C_HANG] = cmd_clear; // see RULE_18
    cause_clr[rsm_pkg::C_SWREQ] = cmd_clear;
    // remaining bits cleared on the falling edge of aux clear after a command
    if (clear_armed_r && aux_d_r && !aux_cause_clear) // see RULE_21
      cause_clr = '1;
  end

  // only aresetn (power-on) touches these flops, so system resets leave them alone
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cause_r <= rsm_pkg::CAUSE_RESET; // see RULE_23
      por_seen_r <= 1'b0;
    end
    else
    begin
      por_seen_r <= 1'b1;
      cause_r <= (cause_r & ~cause_clr) | cause_set; // see RULE_22
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aux_d_r <= 1'b0;
      clear_armed_r <= 1'b0;
    end
    else
    begin
      aux_d_r <= aux_cause_clear;
      if (cmd_clear)
        clear_armed_r <= 1'b1;
      else if (aux_d_r && !aux_cause_clear)
        clear_armed_r <= 1'b0;
    end
  end

  // write path: address and data accepted in either order
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign wr_go = aw_have_r && w_have_r;
  assign cmd_clear = wr_go && aw_addr_r[11:2] == rsm_pkg::OFF_COMMAND[11:2]
    && w_strb_r[0] && w_data_r[rsm_pkg::CMD_CLEAR_BIT]; // see RULE_24

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rsm_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_r == rsm_pkg::OFF_CONTROL || aw_addr_r == rsm_pkg::OFF_CAUSE
            || aw_addr_r == rsm_pkg::OFF_COMMAND) // see RULE_19
          s_axi_bresp <= rsm_pkg::RESP_OKAY;
        else
          s_axi_bresp <= rsm_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hang_dis_r <= rsm_pkg::CONTROL_RESET[rsm_pkg::CTRL_HANG_DIS_BIT];
    else if (wr_go && aw_addr_r == rsm_pkg::OFF_CONTROL && w_strb_r[0])
      hang_dis_r <= w_data_r[rsm_pkg::CTRL_HANG_DIS_BIT]; // see RULE_07
  end

  // read path: one read at a time, answered the cycle after the address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rsm_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rsm_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        rsm_pkg::OFF_CONTROL: s_axi_rdata <= {31'h0, hang_dis_r};
        rsm_pkg::OFF_CAUSE: s_axi_rdata <= {21'h0, cause_r};
        rsm_pkg::OFF_COMMAND: s_axi_rdata <= 32'h0000_0000; // see RULE_24
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= rsm_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // assertions
  property p_supply_hold;
    @(posedge aclk) disable iff (!aresetn)
      !supply_low_n.unreg_n |=> !reset_out.system_reset_n && !reset_out.debug_reset_n;
  endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("supply low not held"); // RULE_02

  property p_hang_debug;
    @(posedge aclk) disable iff (!aresetn)
      hang_rst && !full_rst |=> !reset_out.system_reset_n && reset_out.debug_reset_n;
  endproperty
  a_hang_debug: assert property (p_hang_debug) else $error("hang reset wrong"); // RULE_06

  property p_hang_dis;
    @(posedge aclk) disable iff (!aresetn)
      hang_dis_r && core_hang && !full_rst && !sw_system_reset_request
      |=> reset_out.system_reset_n;
  endproperty
  a_hang_dis: assert property (p_hang_dis) else $error("disabled hang reset"); // RULE_07

  property p_glitch;
    @(posedge aclk) disable iff (!aresetn)
      $rose(ext_reset_pin_n == 1'b0) ##1 ext_reset_pin_n |-> !pin_rst_r;
  endproperty
  a_glitch: assert property (p_glitch) else $error("glitch reached reset"); // RULE_04

  property p_wdog_cause;
    @(posedge aclk) disable iff (!aresetn)
      watchdog_expired |=> cause_r[rsm_pkg::C_WDOG] && !reset_out.debug_reset_n;
  endproperty
  a_wdog_cause: assert property (p_wdog_cause) else $error("watchdog not recorded"); // RULE_15

  property p_cmd_clear;
    @(posedge aclk) disable iff (!aresetn)
      cmd_clear && !hang_rst && !sw_system_reset_request
      |=> !cause_r[rsm_pkg::C_HANG] && !cause_r[rsm_pkg::C_SWREQ];
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("command clear failed"); // RULE_18

  property p_keep;
    @(posedge aclk) disable iff (!aresetn)
      cause_r[rsm_pkg::C_PIN] && !(clear_armed_r && aux_d_r && !aux_cause_clear)
      |=> cause_r[rsm_pkg::C_PIN];
  endproperty
  a_keep: assert property (p_keep) else $error("cause bit lost"); // RULE_22

  property p_sleep;
    @(posedge aclk) disable iff (!aresetn)
      deepest_sleep_mode |=> cause_r[rsm_pkg::C_SLEEP];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not recorded"); // RULE_09

  property p_swreq;
    @(posedge aclk) disable iff (!aresetn)
      sw_system_reset_request |=> cause_r[rsm_pkg::C_SWREQ] && !reset_out.system_reset_n;
  endproperty
  a_swreq: assert property (p_swreq) else $error("sw request missed"); // RULE_08

  c_pin: cover property (@(posedge aclk) disable iff (!aresetn) $rose(pin_rst_r));
  c_hang: cover property (@(posedge aclk) disable iff (!aresetn) hang_rst);
  c_sw_request: cover property (@(posedge aclk) disable iff (!aresetn)
    sw_system_reset_request && !full_rst);
  c_hang_masked: cover property (@(posedge aclk) disable iff (!aresetn)
    core_hang && hang_dis_r);
  c_clear_all: cover property (@(posedge aclk) disable iff (!aresetn)
    clear_armed_r && aux_d_r && !aux_cause_clear);

endmodule // rsm_reset_source_manager

/* bench/rsm_far_side.sv */
// far-side model: supply monitors, reset pin, watchdog, core, energy unit
// assumes the bench calls its tasks from one process in step with aclk
`timescale 1ns/1ps
module rsm_far_side (
  // clock
  input wire logic aclk,
  // sources toward the manager
  output rsm_pkg::rsm_supply_t supply_low_n,
  output logic ext_reset_pin_n,
  output logic watchdog_expired,
  output logic core_hang,
  output logic sw_system_reset_request,
  output logic deepest_sleep_mode,
  output logic deep_sleep_pin_wake,
  output logic aux_cause_clear
);
  logic [8:0] src_r = 9'h000;
  logic pin_low_r = 1'b0;
  logic aux_r = 1'b0;
  // monitor lines are active low, one per supply
  assign supply_low_n = ~{src_r[0], src_r[1], src_r[2], src_r[3]};
  // open drain with pull-up: a released pin reads high
  assign ext_reset_pin_n = pin_low_r ? 1'b0 : 1'b1;
  assign watchdog_expired = src_r[4];
  assign core_hang = src_r[5];
  assign sw_system_reset_request = src_r[6];
  assign deepest_sleep_mode = src_r[7];
  assign deep_sleep_pin_wake = src_r[8];
  assign aux_cause_clear = aux_r;
  task automatic set_src(input int i, input logic v);
    @(posedge aclk);
    src_r[i] <= v;
  endtask
  task automatic pin(input int n);
    @(posedge aclk);
    pin_low_r <= 1'b1;
    repeat (n) @(posedge aclk);
    pin_low_r <= 1'b0;
  endtask
  // aux bit raised then lowered; the bench calls it once after a command and once without
  task automatic aux_seq;
    @(posedge aclk);
    aux_r <= 1'b1;
    @(posedge aclk);
    aux_r <= 1'b0;
  endtask
endmodule // rsm_far_side

/* bench/tb_reset_source_manager.sv */
// bench for the reset source manager, sources driven through rsm_far_side
// assumes cause bits survive system resets and only aresetn, the clear command (bits 5, 6) or the command and aux clear sequence clears them
`timescale 1ns/1ps
module tb_reset_source_manager;
  localparam int FC = 2;
  localparam logic [11:0] CTL = rsm_pkg::OFF_CONTROL;
  localparam logic [11:0] CAU = rsm_pkg::OFF_CAUSE;
  localparam logic [11:0] CMD = rsm_pkg::OFF_COMMAND;
  localparam logic [1:0] OK = rsm_pkg::RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, d, exp_c = 32'h1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_n, wdog, hang, swreq, slp, wake, aux;
  logic [1:0] bresp, rresp, r;
  rsm_pkg::rsm_supply_t sup;
  rsm_pkg::rsm_reset_out_t rst;
  int n_fail = 0;
  int comparisons = 0;
  rsm_far_side far_u (.aclk(aclk), .supply_low_n(sup), .ext_reset_pin_n(pin_n),
    .watchdog_expired(wdog), .core_hang(hang), .sw_system_reset_request(swreq),
    .deepest_sleep_mode(slp), .deep_sleep_pin_wake(wake), .aux_cause_clear(aux));
  rsm_reset_source_manager #(.FILTER_CYC(FC)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .supply_low_n(sup), .ext_reset_pin_n(pin_n), .watchdog_expired(wdog),
    .core_hang(hang), .sw_system_reset_request(swreq), .deepest_sleep_mode(slp),
    .deep_sleep_pin_wake(wake), .aux_cause_clear(aux), .reset_out(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  always #25 aclk = ~aclk;
  task automatic wrap_up;
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic crst(input logic [1:0] e);
    chk("reset_out", {30'h0, e}, {30'h0, rst});
  endtask
  // a hung handshake counts as a mismatch and ends the run
  task automatic tmo;
    n_fail++;
    wrap_up();
  endtask
  task automatic wrc(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e);
    int k;
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      #1;
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
    end
    bready <= 1'b0;
    if (k == 50) tmo();
    chk("bresp", {30'h0, e}, {30'h0, r});
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    logic ta, tv;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      #1;
      ta = arvalid & arready;
      tv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tv) break;
    end
    rready <= 1'b0;
    if (k == 50) tmo();
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic t_regs;
    settle(2);
    crst(2'b11);
    rdc(CTL, 32'h0, OK);
    rdc(CAU, exp_c, OK);
    rdc(CMD, 32'h0, OK);
    rdc(12'h00c, 32'h0, rsm_pkg::RESP_SLVERR);
    wrc(12'h00c, 32'h1, rsm_pkg::RESP_SLVERR);
  endtask
  task automatic t_pin;
    far_u.pin(FC - 1);
    settle(FC + 3);
    crst(2'b11);
    rdc(CAU, exp_c, OK);
    fork
      far_u.pin(FC + 6);
      begin
        settle(FC + 4);
        crst(2'b00);
      end
    join
    settle(FC + 3);
    crst(2'b11);
    exp_c[3] = 1'b1;
    rdc(CAU, exp_c, OK);
  endtask
  // lockup and software request keep the debug side out of reset
  task automatic t_src;
    int i;
    for (i = 0; i < 9; i++)
    begin
      far_u.set_src(i, 1'b1);
      settle(8);
      if (i < 7) crst((i == 5 || i == 6) ? 2'b01 : 2'b00);
      far_u.set_src(i, 1'b0);
      settle(3);
      crst(2'b11);
      exp_c[(i == 2) ? 9 : (i == 3) ? 10 : (i < 2) ? i + 1 : i] = 1'b1;
      rdc(CAU, exp_c, OK);
    end
  endtask
  task automatic t_clr;
    wrc(CMD, 32'h0, OK);
    rdc(CAU, exp_c, OK);
    wrc(CMD, 32'h1, OK);
    exp_c[6:5] = 2'b00;
    rdc(CAU, exp_c, OK);
    wrc(CTL, 32'h1, OK);
    rdc(CTL, 32'h1, OK);
    far_u.set_src(5, 1'b1);
    settle(4);
    crst(2'b11);
    far_u.set_src(5, 1'b0);
    wrc(CTL, 32'h0, OK);
    wrc(CMD, 32'h1, OK);
    far_u.aux_seq();
    settle(3);
    rdc(CAU, 32'h0, OK);
    // aux toggle without a fresh command must leave the causes alone
    far_u.set_src(7, 1'b1);
    far_u.set_src(7, 1'b0);
    far_u.aux_seq();
    settle(3);
    rdc(CAU, 32'h0000_0080, OK);
  endtask
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_pin();
    t_src();
    t_clr();
    wrap_up();
  end
endmodule // tb_reset_source_manager
